// file: verilog/e1oc_pkg.sv
// package: offsets, field positions and reset values for the e1 overhead capture
// assumes: byte-wide register port, four framer ports spaced 0x200 apart
package e1oc_pkg;
  // ==========================================
  // address map
  localparam int unsigned NUM_PORTS = 4;
  localparam logic [11:0] PORT_STRIDE = 12'h200;
  localparam logic [7:0] OFS_ALIGN_WORD = 8'h64;
  localparam logic [7:0] OFS_NONALIGN_WORD = 8'h65;
  localparam logic [7:0] OFS_INTL_EVEN = 8'h66;
  localparam logic [7:0] OFS_INTL_ODD = 8'h67;
  localparam logic [7:0] OFS_REMOTE_ALARM = 8'h68;
  localparam logic [7:0] OFS_ADD_FOUR = 8'h69;
  localparam logic [7:0] OFS_ADD_FIVE = 8'h6A;
  localparam logic [7:0] OFS_ADD_SIX = 8'h6B;
  localparam logic [7:0] OFS_ADD_SEVEN = 8'h6C;
  localparam logic [7:0] OFS_ADD_EIGHT = 8'h6D;
  localparam logic [7:0] REG_RESET = 8'h00;
  // ==========================================
  // non-align word field positions
  localparam int unsigned POS_INTL = 7;
  localparam int unsigned POS_FIXED_ONE = 6;
  localparam int unsigned POS_REMOTE_ALARM = 5;
  localparam int unsigned POS_ADD_FOUR = 4;
  localparam int unsigned POS_ADD_EIGHT = 0;
  localparam int unsigned FRAMES_PER_MF = 16;
endpackage

// file: verilog/e1oc_port.sv
// one framer port: captures time-slot-0 words and per-multiframe bits
// assumes: frame strobe carries the ts0 byte and the frame number 0..15
`timescale 1ns/1ps
module e1oc_port
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ts0_valid,
  input wire logic [3:0] frame_num,
  input wire logic [7:0] ts0_byte,
  output logic [7:0] align_word,
  output logic [7:0] nonalign_word,
  output logic [7:0] intl_even,
  output logic [7:0] intl_odd,
  output logic [7:0] sa_bits [0:5]
);
  // ==========================================
  // shadow collection
  logic [7:0] sh_even;
  logic [7:0] sh_odd;
  logic [7:0] sh_sa [0:5];
  wire logic odd_frame = frame_num[0];
  wire logic [2:0] pair_idx = frame_num[3:1];
  wire logic mf_end = ts0_valid && (frame_num == 4'hF);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      align_word <= e1oc_pkg::REG_RESET;
      nonalign_word <= e1oc_pkg::REG_RESET;
    end
    else if (ts0_valid && !odd_frame)
      align_word <= ts0_byte;
    else if (ts0_valid)
      nonalign_word <= ts0_byte;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh_even <= e1oc_pkg::REG_RESET;
      sh_odd <= e1oc_pkg::REG_RESET;
    end
    else if (ts0_valid && !odd_frame)
      sh_even[pair_idx] <= ts0_byte[e1oc_pkg::POS_INTL];
    else if (ts0_valid)
      sh_odd[pair_idx] <= ts0_byte[e1oc_pkg::POS_INTL];
  end

  // index 0 remote alarm, 1..5 additional bits four..eight
  genvar g;
  generate
    for (g = 0; g < 6; g++)
    begin : g_sa
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          sh_sa[g] <= e1oc_pkg::REG_RESET;
        else if (ts0_valid && odd_frame)
          sh_sa[g][pair_idx] <= ts0_byte[e1oc_pkg::POS_REMOTE_ALARM - g];
      end
    end
  endgenerate

  // ==========================================
  // visible copies: whole multiframe at once, so reads never mix two
  wire logic [7:0] last_odd = {odd_frame ? ts0_byte[e1oc_pkg::POS_INTL] : sh_odd[7], sh_odd[6:0]};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      intl_even <= e1oc_pkg::REG_RESET;
      intl_odd <= e1oc_pkg::REG_RESET;
    end
    else if (mf_end)
    begin
      intl_even <= sh_even;
      intl_odd <= last_odd;
    end
  end

  generate
    for (g = 0; g < 6; g++)
    begin : g_vis
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          sa_bits[g] <= e1oc_pkg::REG_RESET;
        else if (mf_end)
          sa_bits[g] <= {ts0_byte[e1oc_pkg::POS_REMOTE_ALARM - g], sh_sa[g][6:0]};
      end
    end
  endgenerate
endmodule

// file: verilog/e1oc_top.sv
// What this block does
// - the align-frame word register shows the received international bit at bit 7.
// - bits 6..0 of the align-frame word carry the received alignment pattern bits.
// - the non-align word shows international, fixed one, remote alarm and additional bits four..eight at 7..0.
// - international bits of even frames 0..14 sit with frame 2n at bit n.
// - international bits of odd frames 1..15 sit with frame 2n+1 at bit n.
// - remote alarm bits of odd frames 1..15 sit frame 1 at bit 0 up to frame 15 at bit 7.
// - additional bit four of odd frames is gathered the same way.
// - additional bit five of odd frames is gathered the same way.
// - additional bit six of odd frames is gathered the same way.
// - additional bit seven of odd frames is gathered the same way.
// - additional bit eight of odd frames is gathered the same way.
// - each of four ports has its own copy, spaced 0x200 apart.
//
// top: four-port e1 receive overhead capture with byte register port
// assumes: framer strobes come from the same clock domain
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module e1oc_top
#(
  parameter int unsigned PORTS = e1oc_pkg::NUM_PORTS
)
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [PORTS-1:0] TS0_VALID,
  input wire logic [4*PORTS-1:0] FRAME_NUM,
  input wire logic [8*PORTS-1:0] TS0_BYTE,
  input wire logic [11:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA
);
  // ==========================================
  // per-port capture
  logic [7:0] reg_file [0:PORTS-1][0:9];

  genvar p;
  generate
    for (p = 0; p < PORTS; p++)
    begin : g_port
      logic [7:0] sa [0:5];
      e1oc_port u_port
      (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .ts0_valid(TS0_VALID[p]),
        .frame_num(FRAME_NUM[4*p +: 4]),
        .ts0_byte(TS0_BYTE[8*p +: 8]),
        .align_word(reg_file[p][0]),
        .nonalign_word(reg_file[p][1]),
        .intl_even(reg_file[p][2]),
        .intl_odd(reg_file[p][3]),
        .sa_bits(sa)
      );
      assign reg_file[p][4] = sa[0];
      assign reg_file[p][5] = sa[1];
      assign reg_file[p][6] = sa[2];
      assign reg_file[p][7] = sa[3];
      assign reg_file[p][8] = sa[4];
      assign reg_file[p][9] = sa[5];
    end
  endgenerate

  // ==========================================
  // register read decode; writes have no target
  wire logic [2:0] port_sel = ADDR[11:9];
  wire logic [8:0] local_ofs = ADDR[8:0];
  wire logic hit = (port_sel < PORTS) && (local_ofs >= {1'b0, e1oc_pkg::OFS_ALIGN_WORD})
    && (local_ofs <= {1'b0, e1oc_pkg::OFS_ADD_EIGHT});
  wire logic [8:0] idx9 = local_ofs - {1'b0, e1oc_pkg::OFS_ALIGN_WORD};
  wire logic [3:0] idx = idx9[3:0];
  logic [7:0] sel_data;

  always_comb
  begin
    sel_data = 8'h00;
    if (hit)
      sel_data = reg_file[port_sel[1:0]][idx];
  end

  // unmapped reads return zero; no read clears anything
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      RDATA <= 8'h00;
    else if (RD)
      RDATA <= sel_data;
    else
      RDATA <= 8'h00;
  end

  wire logic unused_wr = WR ^ (^WDATA);

  // ==========================================
  // checks
  a_read_latency: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    RD |=> RDATA == $past(sel_data)) else $error("read data wrong");
  a_idle_zero: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !RD |=> RDATA == 8'h00) else $error("read data not zero when idle");
  a_align_cap: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    TS0_VALID[0] && !FRAME_NUM[0] |=> reg_file[0][0] == $past(TS0_BYTE[7:0]))
    else $error("align word not captured");
  a_nonalign_cap: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    TS0_VALID[0] && FRAME_NUM[0] |=> reg_file[0][1] == $past(TS0_BYTE[7:0]))
    else $error("non-align word not captured");
  a_even_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !(TS0_VALID[0] && FRAME_NUM[3:0] == 4'hF) |=> $stable(reg_file[0][2]))
    else $error("even register moved mid multiframe");
  a_alarm_msb: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    TS0_VALID[0] && FRAME_NUM[3:0] == 4'hF |=> reg_file[0][4][7] == $past(TS0_BYTE[5]))
    else $error("frame 15 alarm bit misplaced");
  a_eight_msb: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    TS0_VALID[0] && FRAME_NUM[3:0] == 4'hF |=> reg_file[0][9][7] == $past(TS0_BYTE[0]))
    else $error("frame 15 bit eight misplaced");
  a_odd_msb: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    TS0_VALID[0] && FRAME_NUM[3:0] == 4'hF |=> reg_file[0][3][7] == $past(TS0_BYTE[7]))
    else $error("frame 15 international bit misplaced");
endmodule

// file: dv/e1oc_line_model.sv
// line model: framer-side source of ts0 bytes, all ports in step
// assumes: one clock, design samples on the rising edge
`timescale 1ns/1ps
module e1oc_line_model
(
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] salt,
  input wire logic [3:0] last,
  output logic [3:0] valid = 4'h0,
  output logic [15:0] fnum = 16'h0000,
  output logic [31:0] ts0 = 32'hA5A5A5A5,
  output logic busy = 1'b0
);
  // ====
  // frames 0..last, three cycles apart
  always @(posedge clk)
  begin
    if (go)
    begin
      busy <= 1'b1;
      for (int f = 0; f <= int'(last); f++)
      begin
        for (int p = 0; p < 4; p++)
        begin
          fnum[4*p +: 4] <= 4'(f);
          ts0[8*p +: 8] <= 8'(f * 'h1D + p * 'h35) + salt;
        end
        valid <= 4'hF;
        @(posedge clk);
        valid <= 4'h0;
        // stale byte would hide a late sample
        ts0 <= ~ts0;
        repeat (2) @(posedge clk);
      end
      busy <= 1'b0;
    end
  end
endmodule

// file: dv/e1oc_top_tb.sv
// bench: register reads of captured overhead after model-driven multiframes
// assumes: e1oc_top with four ports, line model beside it
`timescale 1ns/1ps
module e1oc_top_tb;
  logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, go = 1'b0, busy;
  logic [11:0] addr = 12'h000;
  logic [7:0] wdata = 8'h00, rdata, salt = 8'h00;
  logic [3:0] last = 4'h0, valid;
  logic [15:0] fnum;
  logic [31:0] ts0;
  int n_fail = 0, n_compared = 0;
  // ====
  // clock, design, line model
  initial forever #5 clk = ~clk;
  e1oc_top i_dut (.CLK_SYS(clk), .RST_N(rst_n), .TS0_VALID(valid), .FRAME_NUM(fnum), .TS0_BYTE(ts0),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata));
  e1oc_line_model i_line (.clk(clk), .go(go), .salt(salt), .last(last), .valid(valid), .fnum(fnum),
    .ts0(ts0), .busy(busy));
  // ====
  // expectations
  function automatic logic [7:0] fb(int p, int f, logic [7:0] s);
    return 8'(f * 'h1D + p * 'h35) + s;
  endfunction
  function automatic logic [7:0] ex(int p, int o, logic [7:0] sm, logic [7:0] sw, int l);
    logic [7:0] r, b;
    int k;
    k = (o == 'h67) ? 7 : (o == 'h68) ? 5 : 'h6D - o;
    if (o < 'h66)
      return fb(p, (o == 'h64) ? l - l % 2 : l - 1 + l % 2, sw);
    for (int n = 0; n < 8; n++)
    begin
      b = fb(p, 2 * n + int'(o != 'h66), sm);
      r[n] = (o == 'h66) ? b[7] : b[k];
    end
    return r;
  endfunction
  // ====
  // bus tasks
  task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd_chk(logic [11:0] a, logic [7:0] exp);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 cmp($sformatf("reg %h", a), exp, rdata);
  endtask
  task automatic wr_reg(logic [11:0] a, logic [7:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic send(logic [7:0] s, logic [3:0] l);
    salt <= s;
    last <= l;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 100 && busy; i++) @(posedge clk);
    #1;
  endtask
  task automatic chk(logic [7:0] sm, logic [7:0] sw, int l);
    for (int p = 0; p < 4; p++)
      for (int o = 'h64; o <= 'h6D; o++)
      begin
        wr_reg(12'(p * 'h200 + o), ~ex(p, o, sm, sw, l));
        rd_chk(12'(p * 'h200 + o), ex(p, o, sm, sw, l));
        rd_chk(12'(p * 'h200 + o), ex(p, o, sm, sw, l));
      end
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ====
  // tests
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    // port 4 and the offsets either side are unmapped
    for (int a = 'h63; a <= 'h6E; a++)
      for (int p = 0; p < 5; p++)
        rd_chk(12'(p * 'h200 + a), 8'h00);
    send(8'h3C, 4'd15);
    chk(8'h3C, 8'h3C, 15);
    send(8'hC9, 4'd14);
    chk(8'h3C, 8'hC9, 14);
    send(8'hC9, 4'd15);
    chk(8'hC9, 8'hC9, 15);
    end_of_test();
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    n_fail++;
    end_of_test();
  end
endmodule
